// ### pcs_pkg.sv
// package of constants for the program counter and return stack block
// Summary of operation
// RULE_01: program counter is 13 bits, next fetch address
// RULE_02: low counter byte readable and writable by software
// RULE_03: upper five counter bits not directly accessible
// RULE_04: upper bits load only from high latch
// RULE_05: eight-entry 13-bit return stack, own storage
// RULE_06: stack pointer has no software access path
// RULE_07: push on call or interrupt branch
// RULE_08: pop on return, literal return, interrupt exit
// RULE_09: push and pop leave high latch unchanged
// RULE_10: ninth push overwrites first, circularly
// RULE_11: 8K space, branches carry 11-bit page offset
// RULE_12: branch page bits from high latch bits 4:3
// RULE_13: software sets page bits before branching
// RULE_14: full 13-bit counter pushed, returns need no paging
// RULE_15: pointer wraps modulo eight, no overflow flag
package pcs_pkg;
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 5;
  localparam int TGT_W = 11;
  localparam int PAGE_LSB = 3;
  localparam int PAGE_MSB = 4;
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  typedef enum logic [2:0] {
    PCS_OP_STEP = 3'b000,
    PCS_OP_HOLD = 3'b001,
    PCS_OP_JUMP = 3'b011,
    PCS_OP_CALL = 3'b010,
    PCS_OP_RET = 3'b110,
    PCS_OP_INT = 3'b111,
    PCS_OP_LOWWR = 3'b101
  } pcs_op_t;
endpackage

// ### pcs_stack_mem.sv
// eight-word return address memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module pcs_stack_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 13
) (
  input wire logic mclk, // core clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write slot
  input wire logic [DW-1:0] wr_data, // address to store
  input wire logic [AW-1:0] rd_addr, // read slot
  output logic [DW-1:0] rd_data // registered read data
);
  logic [DW-1:0] mem [DEPTH];
  // a word written to the slot being read is passed straight through,
  // so a return right after a call sees the fresh return address
  wire logic same_slot = wr_en && (wr_addr == rd_addr);

  // storage needs no reset; read data does
  always_ff @(posedge mclk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data; // RULE_05
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (ce) begin
      rd_data <= same_slot ? wr_data : mem[rd_addr]; // RULE_14
    end
  end
endmodule
`default_nettype wire

// ### pcs_top.sv
// program counter sequencer with paging and circular return stack
`timescale 1ns/100ps
`default_nettype none
module pcs_top #(
  parameter int DEPTH = pcs_pkg::STK_DEPTH
) (
  input wire logic mclk, // core clock, 40 MHz
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable, freezes all state
  input wire logic [2:0] op, // sequencing op, pcs_pkg::pcs_op_t
  input wire logic [10:0] branch_target, // 11-bit page offset
  input wire logic [7:0] low_wr_data, // new low counter byte
  input wire logic latch_wr, // write strobe for high latch
  input wire logic [7:0] latch_wr_data, // high latch write data
  output logic [12:0] prog_count, // next fetch address
  output logic [7:0] prog_count_low_byte, // readable low byte
  output logic [7:0] prog_count_high_latch, // readable high latch
  output logic stack_ready // status hint, low after two stack ops in a row
);
  logic [12:0] pc_r, pc_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic [2:0] sp_r, sp_nxt;
  logic [12:0] top_word;
  logic ready_r;
  logic pop_pend_r;

  wire is_call = op == pcs_pkg::PCS_OP_CALL;
  wire is_int = op == pcs_pkg::PCS_OP_INT;
  wire is_jump = op == pcs_pkg::PCS_OP_JUMP;
  wire is_ret = op == pcs_pkg::PCS_OP_RET;
  wire is_step = op == pcs_pkg::PCS_OP_STEP;
  wire is_low = op == pcs_pkg::PCS_OP_LOWWR;
  wire do_push = is_call | is_int; // RULE_07
  // page bits come from the latch, offset from the instruction
  wire [1:0] page_sel =
    latch_r[pcs_pkg::PAGE_MSB:pcs_pkg::PAGE_LSB]; // RULE_12
  wire [12:0] far_target = {page_sel, branch_target}; // RULE_11
  // low byte write also reloads upper bits, always via the latch
  wire [12:0] low_load = {latch_r[4:0], low_wr_data}; // RULE_03 RULE_04
  wire [12:0] pc_inc = pc_r + 13'h0001;
  // slot to read ahead: top of stack after this cycle's update
  wire [2:0] rd_slot = sp_nxt - 3'h1;

  // push and pop ride around the ring modulo eight, no flag
  always_comb begin
    sp_nxt = sp_r;
    if (do_push) begin
      sp_nxt = sp_r + 3'h1; // RULE_10 RULE_15
    end else if (is_ret) begin
      sp_nxt = sp_r - 3'h1; // RULE_15
    end
  end

  always_comb begin
    pc_nxt = pc_r;
    if (is_step) begin
      pc_nxt = pc_inc; // RULE_01
    end else if (is_jump || is_call) begin
      pc_nxt = far_target; // RULE_11 RULE_12
    end else if (is_int) begin
      pc_nxt = pcs_pkg::INT_VECTOR;
    end else if (is_ret) begin
      pc_nxt = top_word; // RULE_08 RULE_14
    end else if (is_low) begin
      pc_nxt = low_load; // RULE_04
    end
  end

  // only a software write touches the latch, never the stack
  always_comb begin
    latch_nxt = latch_r; // RULE_09
    if (latch_wr) begin
      latch_nxt = latch_wr_data;
    end
  end

  // return word is read ahead so a pop needs no extra cycle;
  // a call pushes the return address, which is the next step
  pcs_stack_mem #(
    .DEPTH(DEPTH),
    .AW(pcs_pkg::SP_W),
    .DW(pcs_pkg::PC_W)
  ) u_stack (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wr_en(do_push), // RULE_07
    .wr_addr(sp_r), // RULE_10
    .wr_data(is_call ? pc_inc : pc_r), // RULE_14
    .rd_addr(rd_slot),
    .rd_data(top_word)
  );

  // status hint only: low after two stack operations in a row
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pop_pend_r <= 1'b0;
      ready_r <= 1'b1;
    end else if (ce) begin
      pop_pend_r <= do_push | is_ret;
      ready_r <= ~(do_push | is_ret);
    end
  end

  // pointer kept private: no port shows it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_r <= pcs_pkg::PC_RST;
      latch_r <= pcs_pkg::LATCH_RST;
      sp_r <= pcs_pkg::SP_RST; // RULE_06
    end else if (ce) begin
      pc_r <= pc_nxt;
      latch_r <= latch_nxt;
      sp_r <= sp_nxt;
    end
  end

  // outputs registered alongside the state they mirror
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_count <= pcs_pkg::PC_RST;
      prog_count_low_byte <= pcs_pkg::PC_RST[7:0];
      prog_count_high_latch <= pcs_pkg::LATCH_RST;
      stack_ready <= 1'b1;
    end else if (ce) begin
      prog_count <= pc_nxt; // RULE_01
      prog_count_low_byte <= pc_nxt[7:0]; // RULE_02
      prog_count_high_latch <= latch_nxt;
      stack_ready <= ~(do_push | is_ret) | ~pop_pend_r & ready_r;
    end
  end
endmodule
`default_nettype wire

// ### pcs_top_asserts.sv
// port checks for the program counter and return stack
`timescale 1ns/100ps
`default_nettype none
module pcs_top_asserts (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic [2:0] op, // op
  input wire logic [10:0] branch_target, // offset
  input wire logic [7:0] low_wr_data, // low data
  input wire logic latch_wr, // strobe
  input wire logic [12:0] prog_count, // pc
  input wire logic [7:0] prog_count_low_byte, // low
  input wire logic [7:0] prog_count_high_latch // latch
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic [2:0] o = ce ? op : 3'h1; // frozen cycles act as hold
  wire logic [12:0] p = prog_count;
  wire logic [7:0] l = prog_count_high_latch;
  property p_lo; prog_count_low_byte == p[7:0]; endproperty
  a_lo: assert property (p_lo) else $error("low");
  property p_st; o == 3'h0 |=> p == $past(p) + 13'h1; endproperty
  a_st: assert property (p_st) else $error("step");
  property p_br; o[2:1] == 2'h1 |=> p[10:0] == $past(branch_target)
    && p[12:11] == $past(l[4:3]); endproperty
  a_br: assert property (p_br) else $error("branch");
  property p_lw; o == 3'h5 |=> p == {$past(l[4:0]), $past(low_wr_data)};
  endproperty
  a_lw: assert property (p_lw) else $error("low wr");
  property p_in; o == 3'h7 |=> p == pcs_pkg::INT_VECTOR; endproperty
  a_in: assert property (p_in) else $error("vector");
  property p_rt; o == 3'h2 ##1 o == 3'h6 |=> p == $past(p, 2) + 13'h1;
  endproperty
  a_rt: assert property (p_rt) else $error("return");
  property p_hd; o == 3'h1 || o == 3'h4 |=> $stable(p); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_lt; !(ce && latch_wr) |=> $stable(l); endproperty
  a_lt: assert property (p_lt) else $error("latch");
  c_wrap: cover property (o == 3'h2 [*8]);
  c_ret: cover property (o == 3'h2 ##1 o == 3'h6);
  c_int: cover property (o == 3'h7 ##1 o == 3'h6);
endmodule
bind pcs_top pcs_top_asserts i_pcs_top_asserts (.mclk, .rst, .ce, .op,
  .branch_target, .low_wr_data, .latch_wr, .prog_count,
  .prog_count_low_byte, .prog_count_high_latch);
`default_nettype wire

// ### testbench.sv
// self-checking bench for the program counter block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk = 0, rst = 1, ce = 0, lw = 0;
  logic [2:0] op = 3'h1, sp = 3'h0;
  logic [10:0] tg = 11'h000;
  logic [7:0] d8 = 8'h00, ld = 8'h00, lat, ml = 8'h00;
  logic [12:0] pc, mp = 13'h0000, stk [8];
  logic [20:0] q [$];
  int miscompares = 0, checks_done = 0, seed = 40, i;
  always #12.5 mclk = ~mclk;
  pcs_top i_pcs_top (.mclk(mclk), .rst(rst), .ce(ce), .op(op),
    .branch_target(tg), .low_wr_data(d8), .latch_wr(lw),
    .latch_wr_data(ld), .prog_count(pc), .prog_count_low_byte(),
    .prog_count_high_latch(lat), .stack_ready());
  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value latch_pc expected %h seen %h", exp, got);
    end
  endtask
  task automatic drive(input logic [2:0] o, input logic c);
    @(negedge mclk);
    {op, ce} = {o, c};
    {tg, d8, lw, ld} = 28'($random(seed));
    if (c) begin
      case (o)
        3'h0: mp = mp + 13'h1;
        3'h3: mp = {ml[4:3], tg};
        3'h5: mp = {ml[4:0], d8};
        3'h2, 3'h7: begin
          stk[sp] = (o == 3'h2) ? mp + 13'h1 : mp;
          sp = sp + 3'h1;
          mp = (o == 3'h2) ? {ml[4:3], tg} : pcs_pkg::INT_VECTOR;
        end
        3'h6: begin
          sp = sp - 3'h1;
          mp = stk[sp];
        end
      endcase
      // branch uses the latch as it stood before this cycle's write
      if (lw) ml = ld;
      q.push_back({ml, mp});
    end
  endtask
  always @(posedge mclk) begin
    #1;
    if (!rst && ce) check({lat, pc}, q.pop_front());
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst = 0;
    check({lat, pc}, {pcs_pkg::LATCH_RST, pcs_pkg::PC_RST});
    // fill every slot first so later pops never read an unwritten one
    for (i = 0; i < 10; i++) drive(3'h2, 1'b1);
    for (i = 0; i < 800; i++) drive(3'($random(seed)), |2'($random(seed)));
    #30 print_verdict;
  end
  initial begin
    #50000 miscompares++;
    print_verdict;
  end
endmodule
`default_nettype wire
